// ### src/sdp_defs.svh
`ifndef SDP_DEFS_SVH
`define SDP_DEFS_SVH

// calibration character and unlock key
`define SDP_CAL_CHAR 8'h80
`define SDP_KEY0 8'heb
`define SDP_KEY1 8'h5a
`define SDP_KEY2 8'h70
`define SDP_KEY3 8'hcd
// low run of the calibration character, in bit times
`define SDP_CAL_LOW_BITS 4'h8
// break length, received in bit times, sent in characters
`define SDP_BREAK_BITS 4'h9
`define SDP_TX_BREAK_CHARS 3'h4
`define SDP_CHAR_BITS 4'ha
// divisor limits in clocks per bit
`define SDP_DIV_MIN 16'h0004
`define SDP_DIV_MAX 16'h0200
// debug control bit position in the control byte
`define SDP_CTRL_MODE_BIT 7
// host holds line low this long after reset
`define SDP_POST_RESET_LOW_CYC 5000

`endif

// ### src/sdp_pkg.sv
package sdp_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } sdp_char_t;

    typedef struct packed {
        logic breakpoint_instruction;
        logic frame;
        logic collide;
    } sdp_err_t;
endpackage

// ### src/sdp_debug_port.sv
// Functional notes
// - one open-drain half-duplex line; never transmit and receive together.
// - characters are start low, eight data bits lsb first, stop high.
// - idle after reset until calibration character 80h arrives.
// - divisor measured from eight-bit low run of calibration character.
// - baud from system clock, clock/512 down to clock/4.
// - low for nine or more bit times is break; recalibrate.
// - low stop bit flags a framing error.
// - line low while sending a high bit is a collision.
// - on any error abort, send four-character break, reset baud.
// - received break keeps control register and debug mode.
// - unit held in reset during break until line high.
// - in debug mode the cpu fetch idles and halt exits.
// - watchdog refreshed continuously while in debug mode.
// - breakpoint instruction enters debug mode (small package: once unlocked).
// - line low at last reset cycle enters debug mode (large packages).
// - leave debug mode on control bit cleared or any reset.
// - line low in stop mode starts a full system reset.
// - small package: pin is gpio unless unlocked during reset.
// - unlock key 80h then eb,5a,70,cd accepted only.
`timescale 1ns/1ps
`include "sdp_defs.svh"

module sdp_debug_port #(
    parameter bit SMALL_PACKAGE = 1'b0,
    parameter int DIV_WIDTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sysResetActive,
    input wire logic debugLineIn,
    output logic debugLineOut,
    output logic debugLineOe,
    input wire sdp_pkg::sdp_char_t txChar,
    output logic txReady,
    output sdp_pkg::sdp_char_t rxChar,
    output sdp_pkg::sdp_err_t serialError,
    output logic abortCommand,
    output logic baudLocked,
    input wire logic breakpointInstruction,
    input wire logic controlWrite,
    input wire logic [7:0] controlData,
    input wire logic stopMode,
    output logic debugModeControlBit,
    output logic cpuFetchIdle,
    output logic haltExit,
    output logic watchdogRefresh,
    output logic systemResetRequest,
    output logic debugPinUnlocked
);
    typedef enum {ST_CAL_WAIT, ST_CAL_MEASURE, ST_IDLE, ST_RX, ST_TX, ST_BREAK_TX, ST_BREAK_WAIT} sdp_state_t;

    // line synchroniser
    logic sync1Reg, lineReg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1Reg <= 1'b1;
            lineReg <= 1'b1;
        end else begin
            sync1Reg <= debugLineIn;
            lineReg <= sync1Reg;
        end
    end

    sdp_state_t stateReg, stateNext;
    logic [DIV_WIDTH-1:0] divReg, divNext;
    logic [DIV_WIDTH+3:0] cntReg, cntNext;
    logic [DIV_WIDTH+3:0] lowReg;
    logic [3:0] bitReg, bitNext;
    logic [2:0] brkCharReg, brkCharNext;
    logic [9:0] shiftReg, shiftNext;
    logic txLowReg, txLowNext;
    logic lockedReg, lockedNext;
    logic [2:0] keyReg, keyNext;
    logic unlockReg, modeReg, resetSeenReg;
    sdp_pkg::sdp_char_t rxReg, rxNext;
    sdp_pkg::sdp_err_t errReg, errNext;

    // decodes: full bit, half bit, break length
    logic [DIV_WIDTH+3:0] divWide, halfBit, breakLen;
    logic bitDone, lineLow, breakSeen, lineUsable;
    logic [DIV_WIDTH-1:0] measDiv;
    assign divWide = {4'h0, divReg};
    assign halfBit = {5'h00, divReg[DIV_WIDTH-1:1]};
    assign breakLen = divWide * `SDP_BREAK_BITS;
    assign bitDone = (cntReg == divWide - 1'b1);
    // measure counter starts at zero, so the run is one edge longer than it reads
    assign measDiv = DIV_WIDTH'((cntReg + 1'b1) >> 3);
    // key bytes arrive before unlock, so the line is usable during reset
    assign lineUsable = !SMALL_PACKAGE || unlockReg || sysResetActive;
    assign lineLow = lineUsable && !lineReg;
    // break: low run of nine bit times once baud is known
    assign breakSeen = lockedReg && lineLow && (lowReg >= breakLen);

    // low run counter, cleared by a high line
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lowReg <= '0;
        end else if (!lineLow) begin
            lowReg <= '0;
        end else if (!(&lowReg)) begin
            lowReg <= lowReg + 1'b1;
        end
    end

    // serial engine
    always_comb begin
        stateNext = stateReg;
        divNext = divReg;
        cntNext = cntReg + 1'b1;
        bitNext = bitReg;
        brkCharNext = brkCharReg;
        shiftNext = shiftReg;
        txLowNext = 1'b0;
        lockedNext = lockedReg;
        rxNext = '{data: rxReg.data, valid: 1'b0};
        errNext = '0;
        case (stateReg)
            ST_CAL_WAIT: begin
                cntNext = '0;
                if (lineLow) begin
                    stateNext = ST_CAL_MEASURE;
                end
            end
            ST_CAL_MEASURE: begin
                if (!lineLow) begin
                    // eight-bit low run gives clocks per bit
                    divNext = measDiv;
                    if (measDiv >= `SDP_DIV_MIN &&
                        measDiv <= `SDP_DIV_MAX) begin
                        lockedNext = 1'b1;
                        stateNext = ST_IDLE;
                    end else begin
                        stateNext = ST_CAL_WAIT;
                    end
                end else if (cntReg[DIV_WIDTH+3]) begin
                    stateNext = ST_BREAK_WAIT;
                end
            end
            ST_IDLE: begin
                cntNext = '0;
                bitNext = '0;
                if (lineLow) begin
                    stateNext = ST_RX;
                end else if (txChar.valid) begin
                    // transmit only while nothing is received
                    shiftNext = {1'b1, txChar.data, 1'b0};
                    stateNext = ST_TX;
                end
            end
            ST_RX: begin
                if (bitReg == 4'h0 && cntReg == halfBit) begin
                    // start bit must still be low at mid bit
                    cntNext = '0;
                    bitNext = 4'h1;
                    if (!lineLow) begin
                        stateNext = ST_IDLE;
                    end
                end else if (bitReg != 4'h0 && bitDone) begin
                    cntNext = '0;
                    bitNext = bitReg + 1'b1;
                    shiftNext = {lineReg, shiftReg[9:1]}; // lsb first
                    if (bitReg == 4'h9) begin
                        stateNext = ST_IDLE;
                        if (!lineReg) begin
                            errNext.frame = 1'b1;
                            stateNext = ST_BREAK_TX;
                            bitNext = '0;
                            brkCharNext = '0;
                        end else begin
                            rxNext = '{data: shiftReg[9:2], valid: 1'b1};
                        end
                    end
                end
            end
            ST_TX: begin
                txLowNext = !shiftReg[0];
                if (shiftReg[0] && cntReg == halfBit && lineLow) begin
                    errNext.collide = 1'b1;
                    stateNext = ST_BREAK_TX;
                    cntNext = '0;
                    bitNext = '0;
                    brkCharNext = '0;
                end else if (bitDone) begin
                    cntNext = '0;
                    shiftNext = {1'b1, shiftReg[9:1]};
                    bitNext = bitReg + 1'b1;
                    if (bitReg == `SDP_CHAR_BITS - 1'b1) begin
                        stateNext = ST_IDLE;
                    end
                end
            end
            ST_BREAK_TX: begin
                txLowNext = 1'b1; // four characters of low
                lockedNext = 1'b0; // baud logic reset at once
                if (bitDone) begin
                    cntNext = '0;
                    bitNext = bitReg + 1'b1;
                    if (bitReg == `SDP_CHAR_BITS - 1'b1) begin
                        bitNext = '0;
                        brkCharNext = brkCharReg + 1'b1;
                        if (brkCharReg == `SDP_TX_BREAK_CHARS - 1'b1) begin
                            txLowNext = 1'b0;
                            stateNext = ST_BREAK_WAIT;
                        end
                    end
                end
            end
            ST_BREAK_WAIT: begin
                // held until line returns high, then recalibrate
                lockedNext = 1'b0;
                cntNext = '0;
                if (!lineLow) begin
                    stateNext = ST_CAL_WAIT;
                end
            end
            default: stateNext = ST_CAL_WAIT;
        endcase
        // host break wins over idle, receive and transmit, but not over a break already being sent
        if (breakSeen && stateReg != ST_BREAK_TX && stateReg != ST_BREAK_WAIT) begin
            errNext = '{breakpoint_instruction: 1'b1, frame: 1'b0, collide: 1'b0};
            stateNext = ST_BREAK_TX;
            txLowNext = 1'b1;
            cntNext = '0;
            bitNext = '0;
            brkCharNext = '0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stateReg <= ST_CAL_WAIT;
            divReg <= '0;
            cntReg <= '0;
            bitReg <= '0;
            brkCharReg <= '0;
            shiftReg <= '1;
            txLowReg <= 1'b0;
            lockedReg <= 1'b0;
            rxReg <= '0;
            errReg <= '0;
        end else begin
            stateReg <= stateNext;
            divReg <= divNext;
            cntReg <= cntNext;
            bitReg <= bitNext;
            brkCharReg <= brkCharNext;
            shiftReg <= shiftNext;
            txLowReg <= txLowNext;
            lockedReg <= lockedNext;
            rxReg <= rxNext;
            errReg <= errNext;
        end
    end

    // unlock key tracker, only while system reset holds
    logic [7:0] keyByte;
    always_comb begin
        case (keyReg)
            3'h0: keyByte = `SDP_CAL_CHAR;
            3'h1: keyByte = `SDP_KEY0;
            3'h2: keyByte = `SDP_KEY1;
            3'h3: keyByte = `SDP_KEY2;
            default: keyByte = `SDP_KEY3;
        endcase
        keyNext = keyReg;
        if (!sysResetActive) begin
            keyNext = '0;
        end else if (stateReg == ST_CAL_MEASURE && stateNext == ST_IDLE) begin
            keyNext = 3'h1;
        end else if (rxReg.valid && keyReg != 3'h0 && keyReg != 3'h5) begin
            keyNext = (rxReg.data == keyByte) ? keyReg + 1'b1 : 3'h0;
        end
    end

    // debug mode control; break and errors leave it alone
    logic modeNext;
    assign modeNext = (breakpointInstruction && lineUsable)
        || (controlWrite && controlData[`SDP_CTRL_MODE_BIT])
        || (modeReg && !(controlWrite && !controlData[`SDP_CTRL_MODE_BIT]));
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            keyReg <= '0;
            unlockReg <= 1'b0;
            modeReg <= 1'b0;
            resetSeenReg <= 1'b0;
        end else begin
            keyReg <= keyNext;
            unlockReg <= unlockReg || (keyReg == 3'h5 && keyNext == 3'h5 && sysResetActive);
            resetSeenReg <= sysResetActive;
            if (sysResetActive) begin
                modeReg <= 1'b0;
            end else if (resetSeenReg && !SMALL_PACKAGE) begin
                modeReg <= !lineReg; // low at last reset cycle
            end else begin
                modeReg <= modeNext;
            end
        end
    end

    // pin drive: open-drain, enable only while pulling low
    assign debugLineOut = 1'b0;
    assign debugLineOe = txLowReg && lineUsable;
    assign txReady = (stateReg == ST_IDLE) && !lineLow;
    assign rxChar = rxReg;
    assign serialError = errReg;
    assign abortCommand = |errReg;
    assign baudLocked = lockedReg;
    assign debugModeControlBit = modeReg;
    assign cpuFetchIdle = modeReg;
    assign haltExit = modeReg;
    assign watchdogRefresh = modeReg;
    assign systemResetRequest = stopMode && lineLow;
    assign debugPinUnlocked = unlockReg;
endmodule

// ### test/sdp_host_model.sv
`timescale 1ns/1ps
// host end of the shared line: it only pulls low, the pull-up gives high
module sdp_host_model (
    input wire logic clk,
    input wire logic lineLevel,
    output logic pullLow
);
    localparam int BT = 16; // clocks per bit
    initial pullLow = 1'b0; // released
    // start low, data lsb first, stop released unless forced low
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            pullLow <= !f[i];
            repeat (BT) @(posedge clk);
        end
        pullLow <= 1'b0;
    endtask
    // long low level, a break or a post-reset hold
    task automatic hold_low(input int n);
        @(posedge clk);
        pullLow <= 1'b1;
        repeat (n) @(posedge clk);
        pullLow <= 1'b0;
    endtask
    // sample each device bit at its middle
    task automatic recv(output logic [7:0] d, output logic stop);
        wait (lineLevel === 1'b0);
        repeat (BT + BT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            d[i] = lineLevel;
            repeat (BT) @(posedge clk);
        end
        stop = lineLevel;
    endtask
endmodule

// ### test/sdp_debug_port_sva.sv
`timescale 1ns/1ps
// port checks for the debug serial port
module sdp_debug_port_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sysResetActive,
    input wire logic debugLineIn,
    input wire logic debugLineOut,
    input wire logic debugLineOe,
    input wire sdp_pkg::sdp_char_t rxChar,
    input wire sdp_pkg::sdp_err_t serialError,
    input wire logic abortCommand,
    input wire logic baudLocked,
    input wire logic breakpointInstruction,
    input wire logic controlWrite,
    input wire logic [7:0] controlData,
    input wire logic stopMode,
    input wire logic debugModeControlBit,
    input wire logic systemResetRequest
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // clear request that no set competes with
    wire logic modeClear = controlWrite && !controlData[7] && !breakpointInstruction;
    AST_OPEN_DRAIN: assert property (!debugLineOut) else $error("line driven high");
    AST_RX_PULSE: assert property (rxChar.valid |-> baudLocked ##1 !rxChar.valid) else $error("rx pulse");
    AST_ABORT: assert property (abortCommand == |serialError) else $error("abort mismatch");
    AST_ERR_BREAK: assert property (|serialError |-> ##[1:600] debugLineOe) else $error("no break");
    AST_BKPT: assert property (breakpointInstruction && !sysResetActive |=> debugModeControlBit)
        else $error("no entry");
    AST_CLEAR: assert property (modeClear && !sysResetActive && !$past(sysResetActive) |=> !debugModeControlBit)
        else $error("no exit");
    AST_HOLD: assert property (debugModeControlBit && !controlWrite && !sysResetActive |=> debugModeControlBit)
        else $error("mode lost");
    AST_STOP_RESET: assert property (stopMode && !$past(debugLineIn, 2) && !$past(debugLineIn, 3)
        |-> systemResetRequest) else $error("no reset request");
    AST_STOP_ONLY: assert property (systemResetRequest |-> stopMode) else $error("stray request");
    COV_RX: cover property (rxChar.valid);
    COV_FRAME: cover property (serialError.frame);
    COV_BREAK: cover property (serialError.breakpoint_instruction && debugModeControlBit);
    COV_COLLIDE: cover property (serialError.collide);
endmodule
bind sdp_debug_port sdp_debug_port_sva u_sva (.*);

// ### test/single_pin_debug_serial_port_tb_top.sv
`timescale 1ns/1ps
module single_pin_debug_serial_port_tb_top;
    logic clk = 1'b0, nrst = 1'b1, sysResetActive = 1'b0, breakpointInstruction = 1'b0;
    logic controlWrite = 1'b0, stopMode = 1'b0, hostLow, debugLineOut, debugLineOe, txReady;
    logic abortCommand, baudLocked, debugModeControlBit, systemResetRequest, stopBit;
    logic cpuFetchIdle, haltExit, watchdogRefresh, smallOe, smallUnlocked, smallMode;
    logic [7:0] controlData = 8'h00, got;
    sdp_pkg::sdp_char_t txChar = '0, rxChar;
    sdp_pkg::sdp_err_t serialError;
    int n_fail = 0, total_checks = 0, n;
    wire debugLineIn = !(debugLineOe || hostLow); // pull-up unless someone pulls low
    sdp_debug_port u_dut (.*, .debugPinUnlocked());
    // small-package device on a second line that shares the host pull-down
    wire smallLineIn = !(smallOe || hostLow);
    sdp_debug_port #(.SMALL_PACKAGE(1'b1), .DIV_WIDTH(16)) u_dut_small (
        .clk(clk), .nrst(nrst), .sysResetActive(sysResetActive), .debugLineIn(smallLineIn),
        .debugLineOut(), .debugLineOe(smallOe), .txChar('0), .txReady(), .rxChar(), .serialError(),
        .abortCommand(), .baudLocked(), .breakpointInstruction(1'b0), .controlWrite(controlWrite),
        .controlData(controlData), .stopMode(1'b0), .debugModeControlBit(smallMode), .cpuFetchIdle(),
        .haltExit(), .watchdogRefresh(), .systemResetRequest(), .debugPinUnlocked(smallUnlocked)
    );
    sdp_host_model u_host (.clk(clk), .lineLevel(debugLineIn), .pullLow(hostLow));
    always #5 clk = ~clk;
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // calibration character, then lock
    task automatic cal();
        u_host.send(8'h80, 1'b1);
        for (int i = 0; i < 300 && baudLocked !== 1'b1; i++) @(negedge clk);
        check(baudLocked, 1'b1);
    endtask
    // error pulse, length of the answering break, free line again
    task automatic err_break(input int b);
        for (int i = 0; i < 600 && serialError[b] !== 1'b1; i++) @(negedge clk);
        check({serialError[b], abortCommand}, 8'h03);
        n = 0;
        for (int i = 0; i < 600 && debugLineOe !== 1'b1; i++) @(negedge clk);
        for (int i = 0; i < 2000 && debugLineOe === 1'b1; i++) begin
            n++;
            @(negedge clk);
        end
        for (int i = 0; i < 2000 && debugLineIn !== 1'b1; i++) @(negedge clk);
    endtask
    // request one character and hold it until the engine takes it
    task automatic send_tx(input logic [7:0] d);
        @(posedge clk);
        txChar <= '{data: d, valid: 1'b1};
        do @(posedge clk); while (txReady !== 1'b1);
        txChar <= '0;
    endtask
    // one character in, one character out
    task automatic t_rx_tx();
        fork
            u_host.send(8'ha5, 1'b1);
            begin
                for (int i = 0; i < 400 && rxChar.valid !== 1'b1; i++) @(negedge clk);
                got = rxChar.data;
            end
        join
        check(got, 8'ha5);
        fork
            u_host.recv(got, stopBit);
            send_tx(8'h3c);
        join
        check({got, stopBit}, {8'h3c, 1'b1});
    endtask
    // low stop bit: frame error, forty bit times of break, relock
    task automatic t_frame();
        repeat (32) @(posedge clk);
        fork
            u_host.send(8'h55, 1'b0);
            err_break(1);
        join
        check(n >= 630 && n <= 650, 1'b1);
        check(baudLocked, 1'b0);
        cal();
    endtask
    // breakpoint entry, host break keeps mode, control write leaves it
    task automatic t_mode();
        @(posedge clk) breakpointInstruction <= 1'b1;
        @(posedge clk) breakpointInstruction <= 1'b0;
        @(negedge clk) check({debugModeControlBit, cpuFetchIdle, haltExit, watchdogRefresh}, 8'h0f);
        fork
            u_host.hold_low(12 * 16);
            err_break(2);
        join
        check({debugModeControlBit, baudLocked}, 8'h02);
        @(posedge clk) controlWrite <= 1'b1;
        @(posedge clk) controlWrite <= 1'b0;
        @(negedge clk) check({debugModeControlBit, cpuFetchIdle, haltExit, watchdogRefresh}, 8'h00);
        cal();
    endtask
    // low line in stop mode, then a reset ending with the line low
    task automatic t_stop_reset();
        @(posedge clk) stopMode <= 1'b1;
        fork
            u_host.hold_low(5100);
            begin
                repeat (5) @(negedge clk);
                check(systemResetRequest, 1'b1);
                @(posedge clk) stopMode <= 1'b0;
                sysResetActive <= 1'b1;
                repeat (8) @(posedge clk);
                sysResetActive <= 1'b0;
                repeat (3) @(negedge clk);
                check(debugModeControlBit, 1'b1);
            end
        join
    endtask
    // host pulls low inside a high data bit: collision, break, relock
    task automatic t_collide();
        fork
            send_tx(8'hff);
            begin
                wait (debugLineIn === 1'b0);
                repeat (36) @(posedge clk);
                u_host.hold_low(40);
            end
            err_break(0);
        join
        check(n >= 630 && n <= 650, 1'b1);
        check(baudLocked, 1'b0);
        cal();
    endtask
    // small package: key sent during system reset frees the shared pin
    task automatic t_unlock();
        @(negedge clk) check(smallUnlocked, 1'b0);
        @(posedge clk) sysResetActive <= 1'b1;
        repeat (16) @(posedge clk);
        cal();
        u_host.send(8'heb, 1'b1);
        u_host.send(8'h5a, 1'b1);
        u_host.send(8'h70, 1'b1);
        u_host.send(8'hcd, 1'b1);
        @(negedge clk) check(smallUnlocked, 1'b1);
        @(posedge clk) sysResetActive <= 1'b0;
        repeat (3) @(negedge clk);
        check({smallUnlocked, smallOe}, 8'h02);
        cal();
        @(posedge clk) begin
            controlWrite <= 1'b1;
            controlData <= 8'h80;
        end
        @(posedge clk) controlWrite <= 1'b0;
        @(negedge clk) check({smallMode, smallUnlocked}, 8'h03);
    endtask
    // counts and verdict
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check({debugLineOe, baudLocked, debugModeControlBit}, 8'h00);
        cal();
        t_rx_tx();
        t_frame();
        t_mode();
        t_collide();
        t_stop_reset();
        t_unlock();
        give_verdict();
    end
    initial begin
        #600000;
        n_fail++;
        give_verdict();
    end
endmodule
